// ### efic_pkg.sv
// shared constants and types for the event, frequency and interval counter
package efic_pkg;

	localparam int unsigned CLK_HZ = 125000000;
	// interval tick period in nanoseconds
	localparam int unsigned TICK_NS = 10000;
	localparam int unsigned CLK_NS = 8;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
	// frequency gate time in milliseconds
	localparam int unsigned GATE_MS = 1000;
	localparam int unsigned GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
	localparam logic [13:0] EVENT_MAX = 14'h270f;
	localparam logic [16:0] FREQ_KHZ_SPLIT = 17'h02710;
	// 99,990 s expressed in 10 us ticks
	localparam logic [33:0] INTERVAL_MAX = 34'h253fca1c0;
	localparam logic [3:0] CTS_SOURCE = 4'h6;
	localparam int unsigned SOURCE_COUNT = 16;

	typedef enum logic [2:0]
	{
		EFIC_EVENT_INT = 3'h0,
		EFIC_EVENT_EXT = 3'h1,
		EFIC_FREQ_INT = 3'h2,
		EFIC_FREQ_EXT = 3'h3,
		EFIC_IVL_EITHER = 3'h4,
		EFIC_IVL_A_FIRST = 3'h5
	} efic_mode_t;

	typedef enum logic [1:0]
	{
		EFIC_IDLE = 2'h0,
		EFIC_RUN = 2'h1,
		EFIC_WAIT_STOP = 2'h2,
		EFIC_DONE = 2'h3
	} efic_state_t;

	// operator keys, each a one-cycle pulse
	typedef struct packed
	{
		logic start;
		logic repeat_key;
		logic run_key;
	} efic_keys_t;

	typedef struct packed
	{
		logic sense_a;
		logic sense_b;
		logic [3:0] source_a;
		logic [3:0] source_b;
	} efic_route_t;

endpackage

// ### efic_edge_sync.sv
// three-stage synchroniser with agreed-edge detection for one pin
`timescale 1ns/1ps
module efic_edge_sync
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic pin_in,
	input wire logic sense_in,
	output logic level_out,
	output logic edge_out
);
	logic s1;
	logic s2;
	logic s3;
	logic level;
	logic [3:0] fill;

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else if (enable_in)
		begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// edges wait until the stages and the level hold the pin's own value,
	// else a pin idling high looks like a rising edge after reset; a pin
	// that moves after the first clock after reset is still seen as an edge
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			fill <= 4'h0;
		else if (enable_in)
			fill <= {fill[2:0], 1'b1};
	end

	// level moves once the second and third stages agree, or on any cycle until fill[3] is set
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			level <= 1'b0;
		else if (enable_in && (s2 == s3 || !fill[3]))
			level <= s3;
	end

	assign level_out = level;
	assign edge_out = enable_in && fill[3] && (s2 == s3) &&
		(level != s3) && (s3 == sense_in);
endmodule

// ### efic_counter_timer.sv
// event counter, frequency counter and interval timer
`timescale 1ns/1ps
// Overview of operation
// - event edges up to 50 kHz are all counted
// - edge selection: 1 counts rising, 0 counts falling
// - event total shown as four decimal digits 0000 to 9999
// - above 9999 overflow is flagged while counting continues
// - repeat key clears the total and restarts from zero
// - run key stops counting and ends the test
// - source code 06 selects the clear-to-send lead
// - external events count only on trigger crossing reference
// - external frequency counts only trigger crossings of reference
// - frequency measured for routed signals up to 65 kHz
// - below 10000 Hz four digits in Hz, else kHz with two decimals
// - intervals from 10 us to 99,990 s are measured
// - edge sense per input A and B, 0 falling, 1 rising
// - either-first starts on first input, stops on the other
// - either-first reports first input with time after stop edge
// - no stop edge means result stays blank
// - A-first starts on A edge only, result after B edge
// - repeat re-arms the interval timer, run ends it
// - no interval measurement in monitor mode with driver lead
module efic_counter_timer
	import efic_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire efic_keys_t keys_in,
	input wire efic_mode_t mode_in,
	input wire efic_route_t route_in,
	input wire logic [SOURCE_COUNT-1:0] leads_in,
	input wire logic trigger_above_reference_in,
	input wire logic monitor_driver_in,
	output logic active_out,
	output logic result_valid_out,
	output logic [15:0] event_bcd_out,
	output logic count_overflow_out,
	output logic [15:0] freq_bcd_out,
	output logic freq_khz_out,
	output logic [33:0] interval_ticks_out,
	output logic interval_saturated_out,
	output logic b_first_out,
	output logic refused_out,
	output logic [1:0] state_out
);
	efic_state_t state;
	efic_state_t next_state;
	logic raw_a;
	logic raw_b;
	logic edge_a;
	logic edge_b;
	logic ext_mode;
	logic ivl_mode;
	logic [15:0] bcd;
	logic [16:0] freq_acc;
	logic [26:0] gate_cnt;
	logic [10:0] tick_cnt;
	logic [33:0] ticks;
	logic b_first;
	logic [13:0] fdisp;
	logic [15:0] next_bcd;
	logic carry;

	assign ext_mode = (mode_in == EFIC_EVENT_EXT) ||
		(mode_in == EFIC_FREQ_EXT);
	assign ivl_mode = (mode_in == EFIC_IVL_EITHER) ||
		(mode_in == EFIC_IVL_A_FIRST);

	// source mux, code 06 is clear-to-send
	// external modes use the comparator output as input A
	always_comb
	begin
		raw_a = ext_mode ? trigger_above_reference_in :
			leads_in[route_in.source_a];
		raw_b = leads_in[route_in.source_b];
	end

	// sense per input selects the counted edge
	efic_edge_sync u_sync_a
	(
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.enable_in(enable_in),
		.pin_in(raw_a),
		.sense_in(route_in.sense_a),
		.level_out(),
		.edge_out(edge_a)
	);

	efic_edge_sync u_sync_b
	(
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.enable_in(enable_in),
		.pin_in(raw_b),
		.sense_in(route_in.sense_b),
		.level_out(),
		.edge_out(edge_b)
	);

	always_comb
	begin
		next_state = state;
		unique case (state)
			EFIC_IDLE:
			begin
				// refuse interval test when monitoring a driver
				if (keys_in.start && !(ivl_mode && monitor_driver_in))
					next_state = EFIC_RUN;
			end
			EFIC_RUN:
			begin
				// start edge arms the stop wait
				if (ivl_mode && (edge_a ||
					(edge_b && mode_in == EFIC_IVL_EITHER)))
					next_state = EFIC_WAIT_STOP;
			end
			EFIC_WAIT_STOP:
			begin
				if (b_first ? edge_a : edge_b)
					next_state = EFIC_DONE;
			end
			EFIC_DONE:
				next_state = EFIC_DONE;
		endcase
		if (state != EFIC_IDLE && keys_in.repeat_key)
			next_state = EFIC_RUN;
		if (state != EFIC_IDLE && keys_in.run_key)
			next_state = EFIC_IDLE;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			state <= EFIC_IDLE;
		else if (enable_in)
			state <= next_state;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			refused_out <= 1'b0;
		else if (enable_in && keys_in.start && state == EFIC_IDLE)
			refused_out <= ivl_mode && monitor_driver_in;
	end

	// decimal increment across four digits
	always_comb
	begin
		carry = 1'b1;
		next_bcd = bcd;
		for (int i = 0; i < 4; i++)
		begin
			if (carry)
			begin
				if (bcd[i*4 +: 4] == 4'h9)
					next_bcd[i*4 +: 4] = 4'h0;
				else
				begin
					next_bcd[i*4 +: 4] = bcd[i*4 +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
	end

	// event total, one edge per clock is far above 50 kHz
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			bcd <= 16'h0000;
			count_overflow_out <= 1'b0;
		end
		else if (enable_in)
		begin
			// a start and a repeat both begin a fresh total
			if (next_state == EFIC_RUN &&
				(state != EFIC_RUN || keys_in.repeat_key))
			begin
				bcd <= 16'h0000;
				count_overflow_out <= 1'b0;
			end
			else if (state == EFIC_RUN && !ivl_mode &&
				(mode_in == EFIC_EVENT_INT || mode_in == EFIC_EVENT_EXT)
				&& edge_a)
			begin
				bcd <= next_bcd;
				// wraps past 9999 but the flag keeps the overflow visible
				if (bcd == 16'h9999)
					count_overflow_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			event_bcd_out <= 16'h0000;
		else if (enable_in)
			event_bcd_out <= bcd;
	end

	// one-second gate of input A cycles, counted on the edge selected by sense_a
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			gate_cnt <= 27'h0;
			freq_acc <= 17'h0;
			freq_bcd_out <= 16'h0000;
			freq_khz_out <= 1'b0;
		end
		else if (enable_in)
		begin
			if (state != EFIC_RUN || ivl_mode)
			begin
				gate_cnt <= 27'h0;
				freq_acc <= 17'h0;
			end
			else if (gate_cnt == 27'(GATE_CYCLES - 1))
			begin
				gate_cnt <= 27'h0;
				freq_acc <= 17'h0;
				// switch to kHz with two decimals at 10000 Hz
				freq_khz_out <= freq_acc >= FREQ_KHZ_SPLIT;
				freq_bcd_out <= to_bcd(fdisp);
			end
			else
			begin
				gate_cnt <= gate_cnt + 27'h1;
				if (edge_a)
					freq_acc <= freq_acc + 17'h1;
			end
		end
	end

	assign fdisp = (freq_acc >= FREQ_KHZ_SPLIT) ?
		14'(freq_acc / 17'h0000a) : freq_acc[13:0];

	function automatic logic [15:0] to_bcd(input logic [13:0] v);
		logic [15:0] r;
		r[3:0] = 4'(v % 14'h000a);
		r[7:4] = 4'((v / 14'h000a) % 14'h000a);
		r[11:8] = 4'((v / 14'h0064) % 14'h000a);
		r[15:12] = 4'((v / 14'h03e8) % 14'h000a);
		return r;
	endfunction

	// 10 us ticks between start and stop, saturating
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			tick_cnt <= 11'h0;
			ticks <= 34'h0;
			b_first <= 1'b0;
		end
		else if (enable_in)
		begin
			if (state == EFIC_RUN)
			begin
				tick_cnt <= 11'h0;
				ticks <= 34'h0;
				// remember which input started the timing
				b_first <= !edge_a && edge_b;
			end
			else if (state == EFIC_WAIT_STOP)
			begin
				if (tick_cnt == 11'(TICK_CYCLES - 1))
				begin
					tick_cnt <= 11'h0;
					if (ticks != INTERVAL_MAX)
						ticks <= ticks + 34'h1;
				end
				else
					tick_cnt <= tick_cnt + 11'h1;
			end
		end
	end

	// result shown only after the stop edge
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			result_valid_out <= 1'b0;
			interval_ticks_out <= 34'h0;
			interval_saturated_out <= 1'b0;
			b_first_out <= 1'b0;
		end
		else if (enable_in)
		begin
			if (state == EFIC_WAIT_STOP && next_state == EFIC_DONE)
			begin
				result_valid_out <= 1'b1;
				interval_ticks_out <= ticks;
				interval_saturated_out <= ticks == INTERVAL_MAX;
				b_first_out <= b_first;
			end
			else if (next_state != EFIC_DONE)
				result_valid_out <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			active_out <= 1'b0;
			state_out <= 2'h0;
		end
		else if (enable_in)
		begin
			active_out <= next_state != EFIC_IDLE;
			state_out <= next_state;
		end
	end
endmodule

// ### efic_chk.sv
// concurrent checks on the counter and timer ports
`timescale 1ns/1ps
module efic_chk
	import efic_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire efic_keys_t keys_in,
	input wire efic_mode_t mode_in,
	input wire logic monitor_driver_in,
	input wire logic result_valid_out,
	input wire logic count_overflow_out,
	input wire logic [15:0] event_bcd_out,
	input wire logic [33:0] interval_ticks_out,
	input wire logic interval_saturated_out,
	input wire logic refused_out,
	input wire logic [1:0] state_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	logic go, key;
	assign go = enable_in && keys_in.start && state_out == 2'h0;
	assign key = enable_in && state_out != 2'h0;
	property p_refuse;
		go && mode_in >= EFIC_IVL_EITHER && monitor_driver_in
			|=> refused_out && state_out == 2'h0;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refuse");
	property p_start;
		go && !(mode_in >= EFIC_IVL_EITHER && monitor_driver_in)
			|=> state_out == 2'h1;
	endproperty
	a_start: assert property (p_start) else $error("start");
	property p_stop;
		key && keys_in.run_key |=> state_out == 2'h0 && !result_valid_out;
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_rearm;
		key && keys_in.repeat_key && !keys_in.run_key
			|=> state_out == 2'h1 && !count_overflow_out && !result_valid_out;
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearm");
	property p_blank;
		result_valid_out |-> state_out == 2'h3;
	endproperty
	a_blank: assert property (p_blank) else $error("blank");
	property p_digit;
		event_bcd_out[3:0] < 4'ha && event_bcd_out[7:4] < 4'ha
			&& event_bcd_out[11:8] < 4'ha && event_bcd_out[15:12] < 4'ha;
	endproperty
	a_digit: assert property (p_digit) else $error("digit");
	property p_sat;
		interval_saturated_out |-> interval_ticks_out == INTERVAL_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("saturate");
	property p_hold;
		result_valid_out && !keys_in.repeat_key && !keys_in.run_key
			|=> result_valid_out && $stable(interval_ticks_out);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule
bind efic_counter_timer efic_chk chk (.mclk_in, .reset_in, .enable_in,
	.keys_in, .mode_in, .monitor_driver_in, .result_valid_out,
	.count_overflow_out, .event_bcd_out, .interval_ticks_out,
	.interval_saturated_out, .refused_out, .state_out);

// ### efic_lead_model.sv
// interface leads of the data set under test
`timescale 1ns/1ps
module efic_lead_model
(
	input wire logic mclk_in,
	input wire logic cts_in,
	input wire logic second_in,
	output logic [15:0] leads_out
);
	logic [15:0] busy = '0;
	// other leads keep moving so a wrong source pick gets counted
	always @(posedge mclk_in)
		busy <= busy + 16'h1;
	assign leads_out = {busy[15:9], second_in, busy[7], cts_in, busy[5:0]};
endmodule

// ### event_freq_interval_counter_bench.sv
// self-checking bench for the event, frequency and interval counter
`timescale 1ns/1ps
module event_freq_interval_counter_bench;
	import efic_pkg::*;
	logic mclk_in = 0, reset_in = 1, cts = 1, sec = 1, trig = 0, mon = 0;
	logic act, vld, over, sat, bf, ref_o;
	logic en = 1, fkhz;
	logic [15:0] leads, bcd, fbcd, prev_bcd;
	logic [33:0] tk;
	logic [1:0] st;
	efic_keys_t keys = '0;
	efic_mode_t mode = EFIC_EVENT_INT;
	efic_route_t route = '0;
	int fail_count = 0, n_compared = 0, cyc = 0;
	efic_lead_model lm (.mclk_in, .cts_in(cts), .second_in(sec),
		.leads_out(leads));
	efic_counter_timer uut (.mclk_in, .reset_in, .enable_in(en),
		.keys_in(keys), .mode_in(mode), .route_in(route), .leads_in(leads),
		.trigger_above_reference_in(trig), .monitor_driver_in(mon),
		.active_out(act), .result_valid_out(vld), .event_bcd_out(bcd),
		.count_overflow_out(over), .freq_bcd_out(fbcd), .freq_khz_out(fkhz),
		.interval_ticks_out(tk), .interval_saturated_out(sat),
		.b_first_out(bf), .refused_out(ref_o), .state_out(st));
	initial forever #4 mclk_in = ~mclk_in;
	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic press(efic_keys_t k);
		keys = k;
		step(1);
		keys = '0;
	endtask
	// slow enough that the synchroniser stages agree on every level
	task automatic wiggle(int which, int n);
		repeat (2 * n)
		begin
			case (which)
				0: cts = ~cts;
				1: sec = ~sec;
				default: trig = ~trig;
			endcase
			step(12);
		end
	endtask
	initial
	begin
		step(6);
		reset_in = 0;
		// lead 6 to input A, lead 8 to input B
		route = '{1'b1, 1'b1, 4'h6, 4'h8};
		for (int i = 0; i < 4; i++)
		begin
			mode = efic_mode_t'(i / 2);
			route.sense_a = i[0];
			// a mode switch moves the input mux, let that settle first
			step(8);
			press(3'h4);
			wiggle(i < 2 ? 0 : 2, 3 + i);
			if (i > 1)
				wiggle(0, 2);
			step(8);
			check("events", 34'(bcd), 34'(3 + i));
			check("overflow", 34'(over), 34'h0);
			press(3'h2);
			step(4);
			check("cleared", 34'(bcd), 34'h0);
			press(3'h1);
			step(1);
			check("stopped", 34'(st), 34'h0);
		end
		// no one-second gate can close in so short a run
		for (int f = 2; f < 4; f++)
		begin
			mode = efic_mode_t'(f);
			step(8);
			press(3'h4);
			wiggle(f == 2 ? 0 : 2, 3);
			check("active", 34'(act), 34'h1);
			check("freq blank", 34'(fbcd), 34'h0);
			check("freq unit", 34'(fkhz), 34'h0);
			press(3'h1);
		end
		// a fast lead drives the total past its four-digit range
		mode = EFIC_EVENT_INT;
		route = '{1'b1, 1'b1, 4'h1, 4'h8};
		step(8);
		press(3'h4);
		step(40100);
		check("overflow set", 34'(over), 34'h1);
		prev_bcd = bcd;
		step(40);
		check("counting on", 34'(bcd != prev_bcd), 34'h1);
		press(3'h1);
		route.source_a = 4'h6;
		step(8);
		mode = EFIC_IVL_A_FIRST;
		mon = 1;
		press(3'h4);
		step(1);
		check("refused", 34'(ref_o), 34'h1);
		check("idle", 34'(st), 34'h0);
		mon = 0;
		sec = 0;
		route = '{1'b0, 1'b1, 4'h6, 4'h8};
		press(3'h4);
		wiggle(1, 1);
		check("armed", 34'(st), 34'h1);
		cts = 0;
		step(2500);
		check("blank", 34'(vld), 34'h0);
		// while frozen the stop edge must not be taken
		en = 0;
		sec = 1;
		step(10);
		check("frozen", 34'(vld), 34'h0);
		en = 1;
		step(10);
		check("valid", 34'(vld), 34'h1);
		check("ticks", 34'(tk > 34'h0 && tk < 34'h4), 34'h1);
		check("saturated", 34'(sat), 34'h0);
		press(3'h2);
		step(1);
		check("rearmed", 34'(vld), 34'h0);
		press(3'h1);
		mode = EFIC_IVL_EITHER;
		route = '{1'b1, 1'b1, 4'h6, 4'h8};
		sec = 0;
		step(10);
		press(3'h4);
		step(4);
		sec = 1;
		step(20);
		check("timing", 34'(st), 34'h2);
		cts = 1;
		step(10);
		check("b first", 34'(bf), 34'h1);
		check("done", 34'(vld), 34'h1);
		press(3'h1);
		step(1);
		check("ended", 34'(act), 34'h0);
		// one lead on both inputs: a 20 us period is 2 ticks, one count slack
		mode = EFIC_IVL_A_FIRST;
		route = '{1'b1, 1'b1, 4'h6, 4'h6};
		step(8);
		press(3'h4);
		repeat (4)
		begin
			cts = ~cts;
			step(1250);
		end
		check("period valid", 34'(vld), 34'h1);
		check("period", 34'(tk >= 34'h1 && tk <= 34'h3), 34'h1);
		press(3'h1);
		step(1);
		end_of_test();
	end
endmodule
